// ### hdl/bmst_regs.svh
`ifndef BMST_REGS_SVH
`define BMST_REGS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define BMST_CTRL_OFS 8'h00
`define BMST_SLOT_OFS 8'h04
`define BMST_TIDX_OFS 8'h08
`define BMST_TCFG_OFS 8'h0c
`define BMST_TFLT_OFS 8'h10
`define BMST_EXCM_OFS 8'h14
`define BMST_PATT_OFS 8'h18
`define BMST_STAT_OFS 8'h1c

// ************************************************************
// field positions
// ************************************************************
`define BMST_CTRL_REC 0
`define BMST_CTRL_STOP 1
`define BMST_CTRL_ARM0 2
`define BMST_CTRL_ARM1 3
`define BMST_CFG_KIND_LO 0
`define BMST_CFG_STROBE 2
`define BMST_CFG_IRQ 3
`define BMST_CFG_CLR_LO 8
`define BMST_CFG_SET_LO 16
`define BMST_FLT_NEXT_LO 16
`define BMST_FLT_EOM_LO 24
`define BMST_FAULT_ANY 15
`define BMST_FAULT_STATUS 11
`define BMST_STAT_ACTIVE 8

// ************************************************************
// reset values and counts
// ************************************************************
`define BMST_EXC_MASK_RST 11'h7ff
`define BMST_TCB_COUNT 254
`define BMST_LINK_OFF 8'hff

`endif

// ### hdl/bmst_pkg.sv
package bmst_pkg;

  typedef enum logic [1:0] {
    BMST_ERROR_COND,
    BMST_EXT_EVENT,
    BMST_RX_WORD,
    BMST_DATA_VALUE
  } bmst_kind_type;

endpackage : bmst_pkg

// ### hdl/bmst_slot_eval.sv
`timescale 1ns/1ns
`include "bmst_regs.svh"

// one armed trigger slot, purely combinational
module bmst_slot_eval
(
  // slot setup
  input wire logic armed,
  input wire logic [7:0] tcb_idx,
  input wire logic [1:0] kind,
  input wire logic [15:0] fault_select,
  input wire logic [7:0] next_link,
  input wire logic [7:0] eom_link,
  // events
  input wire logic word_valid,
  input wire logic [15:0] fault_vec,
  input wire logic ext_pulse,
  // result
  output logic live,
  output logic hit
);

  bmst_pkg::bmst_kind_type kind_e;

  always_comb
  begin
    kind_e = bmst_pkg::bmst_kind_type'(kind);
    // an index past the stored blocks reads as no block
    live = armed && (tcb_idx < 8'(`BMST_TCB_COUNT));
    hit = 1'b0;
    if (live)
    begin
      unique case (kind_e)
        bmst_pkg::BMST_ERROR_COND:
          hit = word_valid && |(fault_vec & fault_select); // [R1] [R2] [R14] [R21]
        bmst_pkg::BMST_EXT_EVENT:
          hit = ext_pulse; // [R1] [R8] [R14]
        bmst_pkg::BMST_RX_WORD,
        bmst_pkg::BMST_DATA_VALUE:
          hit = 1'b0; // [R1]
      endcase
    end
    // links are single stage here; 0xff means no chaining, anything else is not followed
    if ((next_link != `BMST_LINK_OFF) || (eom_link != `BMST_LINK_OFF))
    begin
      hit = hit; // [R9]
    end
  end

endmodule : bmst_slot_eval

// ### hdl/bmst_trigger.sv
`timescale 1ns/1ns
`include "bmst_regs.svh"

// Operation
// R1: trigger kind 0 error, 1 external
// R2: error trigger fires on any selected fault
// R3: fire yields capture start or stop event
// R4: bit 15 is OR of bits 14..0
// R5: upper fault bits 14 down to 8
// R6: lower fault bits 7 down to 0
// R7: status exception gated by mask, reset 0x07ff
// R8: external trigger fires on input pin pulse
// R9: links 0xff disabled, single stage only
// R10: strobe output when strobe enabled and fired
// R11: interrupt when irq enabled and fired
// R12: fire clears pattern bits in clear mask
// R13: fire sets pattern bits in set mask
// R14: kinds use only their own fields
// R15: two trigger slots evaluated in parallel
// R16: 254 stored control blocks, indexed
// R17: interrupt reports the firing block index
// R18: recording without trigger starts on message
// R19: external input synchronised, one-cycle edge pulse
// R20: clear and set same cycle, set wins; within one block only, a slot 1 clear still drops a bit set by slot 0
// R21: fire at most one cycle after error
module bmst_trigger
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // word decoder faults
  input wire logic word_valid,
  input wire logic other_bus_reply_fault,
  input wire logic low_word_count_fault,
  input wire logic high_word_count_fault,
  input wire logic [10:0] status_exception_bits,
  input wire logic terminal_address_fault,
  input wire logic early_response_fault,
  input wire logic illegal_command_fault,
  input wire logic dual_channel_transmit_fault,
  input wire logic interword_spacing_fault,
  input wire logic inverted_sync_fault,
  input wire logic word_check_bit_fault,
  input wire logic low_bit_count_fault,
  input wire logic high_bit_count_fault,
  input wire logic biphase_coding_fault,
  input wire logic no_response_fault,
  input wire logic message_start,
  // external trigger pins
  input wire logic trig_in,
  output logic trig_out,
  // capture and host
  output logic capture_event,
  output logic capture_active,
  output logic [7:0] status_pattern,
  output logic trig_irq,
  output logic [7:0] trig_irq_tcb
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_sel

  function automatic logic [7:0] apply_pattern(input logic [7:0] cur, input logic [7:0] clr,
                                               input logic [7:0] set);
    return (cur & ~clr) | set; // [R12] [R13] [R20]
  endfunction : apply_pattern

  // ************************************************************
  // registers and control block store
  // ************************************************************
  logic [3:0] ctrl_r;
  logic [15:0] slot_r;
  logic [7:0] tidx_r;
  logic [10:0] exc_mask_r;
  logic [7:0] pattern_r;
  logic [7:0] pattern_nxt;
  logic active_r;
  logic [7:0] last_tcb_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [23:0] cfg_mem [0:`BMST_TCB_COUNT-1]; // [R16]
  logic [31:0] flt_mem [0:`BMST_TCB_COUNT-1]; // [R16]

  logic acc;
  logic wr;
  logic tidx_ok;
  logic [23:0] cfg_cur;
  logic [31:0] flt_cur;

  assign acc = wb_cyc && wb_stb && !ack_r;
  assign wr = acc && wb_we;
  assign tidx_ok = tidx_r < 8'(`BMST_TCB_COUNT);
  assign cfg_cur = tidx_ok ? cfg_mem[tidx_r] : 24'h000000;
  assign flt_cur = tidx_ok ? flt_mem[tidx_r] : 32'h00000000;

  // ************************************************************
  // synchroniser and fault vector
  // ************************************************************
  logic [2:0] trig_sync_r;
  logic ext_pulse;
  logic [15:0] fault_vec;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      trig_sync_r <= 3'b000;
    else
      trig_sync_r <= {trig_sync_r[1:0], trig_in}; // [R19]
  end

  assign ext_pulse = trig_sync_r[1] && !trig_sync_r[2]; // [R19]

  always_comb
  begin
    fault_vec[14] = other_bus_reply_fault; // [R5]
    fault_vec[13] = low_word_count_fault; // [R5]
    fault_vec[12] = high_word_count_fault; // [R5]
    fault_vec[11] = |(status_exception_bits & exc_mask_r); // [R5] [R7]
    fault_vec[10] = terminal_address_fault; // [R5]
    fault_vec[9] = early_response_fault; // [R5]
    fault_vec[8] = illegal_command_fault; // [R5]
    fault_vec[7] = dual_channel_transmit_fault; // [R6]
    fault_vec[6] = interword_spacing_fault; // [R6]
    fault_vec[5] = inverted_sync_fault; // [R6]
    fault_vec[4] = word_check_bit_fault; // [R6]
    fault_vec[3] = low_bit_count_fault; // [R6]
    fault_vec[2] = high_bit_count_fault; // [R6]
    fault_vec[1] = biphase_coding_fault; // [R6]
    fault_vec[0] = no_response_fault; // [R6]
    fault_vec[15] = |fault_vec[14:0]; // [R4]
  end

  // ************************************************************
  // two parallel slots
  // ************************************************************
  logic [1:0] live;
  logic [1:0] hit;
  logic [7:0] sidx [0:1];
  logic [23:0] scfg [0:1];
  logic [31:0] sflt [0:1];

  for (genvar s = 0; s < 2; s++)
  begin : g_slot
    assign sidx[s] = slot_r[s*8 +: 8];
    assign scfg[s] = (sidx[s] < 8'(`BMST_TCB_COUNT)) ? cfg_mem[sidx[s]] : 24'h000000;
    assign sflt[s] = (sidx[s] < 8'(`BMST_TCB_COUNT)) ? flt_mem[sidx[s]] : 32'h00000000;

    bmst_slot_eval u_eval
    (
      .armed(ctrl_r[`BMST_CTRL_ARM0 + s]),
      .tcb_idx(sidx[s]),
      .kind(scfg[s][`BMST_CFG_KIND_LO +: 2]),
      .fault_select(sflt[s][15:0]),
      .next_link(sflt[s][`BMST_FLT_NEXT_LO +: 8]),
      .eom_link(sflt[s][`BMST_FLT_EOM_LO +: 8]),
      .word_valid(word_valid),
      .fault_vec(fault_vec),
      .ext_pulse(ext_pulse),
      .live(live[s]),
      .hit(hit[s]) // [R15]
    );
  end

  // ************************************************************
  // fire decisions
  // ************************************************************
  logic fire;
  logic any_strobe;
  logic any_irq;
  logic [7:0] fire_tcb;
  logic default_start;

  always_comb
  begin
    pattern_nxt = pattern_r;
    // slot 1 applied last so its set bits survive a slot 0 clear
    for (int s = 0; s < 2; s++)
    begin
      if (hit[s])
      begin
        pattern_nxt = apply_pattern(pattern_nxt, scfg[s][`BMST_CFG_CLR_LO +: 8],
                                    scfg[s][`BMST_CFG_SET_LO +: 8]);
      end
    end
  end

  assign fire = |hit; // [R3]
  assign any_strobe = (hit[0] && scfg[0][`BMST_CFG_STROBE]) || (hit[1] && scfg[1][`BMST_CFG_STROBE]);
  assign any_irq = (hit[0] && scfg[0][`BMST_CFG_IRQ]) || (hit[1] && scfg[1][`BMST_CFG_IRQ]);
  // slot 0 wins the reported index when both raise an interrupt
  assign fire_tcb = (hit[0] && scfg[0][`BMST_CFG_IRQ]) ? sidx[0] : sidx[1];
  assign default_start = ctrl_r[`BMST_CTRL_REC] && !(|live) && message_start && !active_r; // [R18]

  // ************************************************************
  // event outputs
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_out <= 1'b0;
      trig_irq <= 1'b0;
      trig_irq_tcb <= 8'h00;
      capture_event <= 1'b0;
    end
    else
    begin
      trig_out <= any_strobe; // [R10]
      trig_irq <= any_irq; // [R11]
      if (any_irq)
        trig_irq_tcb <= fire_tcb; // [R17]
      capture_event <= fire || default_start; // [R3] [R18]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_r <= 1'b0;
      last_tcb_r <= `BMST_LINK_OFF;
    end
    else if (fire)
    begin
      active_r <= !ctrl_r[`BMST_CTRL_STOP]; // [R3]
      last_tcb_r <= hit[0] ? sidx[0] : sidx[1];
    end
    else if (default_start)
      active_r <= 1'b1; // [R18]
  end

  assign capture_active = active_r;
  assign status_pattern = pattern_r;

  // ************************************************************
  // pattern register: hardware fire wins over a software write
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pattern_r <= 8'h00;
    else if (fire)
      pattern_r <= pattern_nxt; // [R12] [R13] [R20]
    else if (wr && wb_adr == `BMST_PATT_OFS && wb_sel[0])
      pattern_r <= wb_dat_w[7:0];
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= 4'h0;
      slot_r <= {`BMST_LINK_OFF, `BMST_LINK_OFF};
      tidx_r <= 8'h00;
      exc_mask_r <= `BMST_EXC_MASK_RST; // [R7]
    end
    else if (wr)
    begin
      unique case (wb_adr)
        `BMST_CTRL_OFS: ctrl_r <= 4'(merge_sel({28'h0000000, ctrl_r}, wb_dat_w, wb_sel));
        `BMST_SLOT_OFS: slot_r <= 16'(merge_sel({16'h0000, slot_r}, wb_dat_w, wb_sel));
        `BMST_TIDX_OFS: tidx_r <= 8'(merge_sel({24'h000000, tidx_r}, wb_dat_w, wb_sel));
        `BMST_EXCM_OFS: exc_mask_r <= 11'(merge_sel({21'h0, exc_mask_r}, wb_dat_w, wb_sel));
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (wr && tidx_ok && wb_adr == `BMST_TCFG_OFS)
      cfg_mem[tidx_r] <= 24'(merge_sel({8'h00, cfg_cur}, wb_dat_w, wb_sel));
    if (wr && tidx_ok && wb_adr == `BMST_TFLT_OFS)
      flt_mem[tidx_r] <= merge_sel(flt_cur, wb_dat_w, wb_sel);
  end

  // ************************************************************
  // bus answer: one wait-free cycle, unmapped reads give zero
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= acc;
      if (acc && !wb_we)
      begin
        unique case (wb_adr)
          `BMST_CTRL_OFS: rdat_r <= {28'h0000000, ctrl_r};
          `BMST_SLOT_OFS: rdat_r <= {16'h0000, slot_r};
          `BMST_TIDX_OFS: rdat_r <= {24'h000000, tidx_r};
          `BMST_TCFG_OFS: rdat_r <= {8'h00, cfg_cur};
          `BMST_TFLT_OFS: rdat_r <= flt_cur;
          `BMST_EXCM_OFS: rdat_r <= {21'h0, exc_mask_r};
          `BMST_PATT_OFS: rdat_r <= {24'h000000, pattern_r};
          `BMST_STAT_OFS: rdat_r <= {23'h0, active_r, last_tcb_r};
          default: rdat_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_ack = ack_r;
  assign wb_dat_r = rdat_r;

endmodule : bmst_trigger

// ### dv/bmst_trigger_checker.sv
`timescale 1ns/1ns
`include "bmst_regs.svh"

// ****
// port checker
// ****
module bmst_trigger_checker
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic wb_ack,
  // events
  input wire logic word_valid,
  input wire logic message_start,
  input wire logic trig_in,
  // results
  input wire logic trig_out,
  input wire logic capture_event,
  input wire logic capture_active,
  input wire logic [7:0] status_pattern,
  input wire logic trig_irq,
  input wire logic [7:0] trig_irq_tcb
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_ack_answer: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("request not acked");
  a_ack_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("ack too long");
  a_strobe_fire: assert property (trig_out |-> capture_event)
    else $error("strobe without fire");
  a_irq_fire: assert property (trig_irq |-> capture_event)
    else $error("irq without fire");
  // the pin path runs through a synchroniser, hence the older samples
  a_fire_cause: assert property (capture_event |-> $past(word_valid) || $past(message_start)
    || $past(trig_in, 3) || $past(trig_in, 4))
    else $error("fire without cause");
  a_pattern_cause: assert property (!$stable(status_pattern) |-> capture_event
    || (wb_ack && wb_we && wb_adr == `BMST_PATT_OFS))
    else $error("pattern moved without cause");
  a_index_hold: assert property (!trig_irq |-> $stable(trig_irq_tcb))
    else $error("irq index moved");
  a_active_rise: assert property ($rose(capture_active) |-> capture_event)
    else $error("capture started silently");
  a_ext_once: assert property (trig_in [*8] |-> !capture_event || $past(word_valid))
    else $error("held pin fired again");

  c_irq: cover property (trig_irq);
  c_strobe: cover property (trig_out && capture_event);
  c_start: cover property ($rose(capture_active));
endmodule : bmst_trigger_checker

bind bmst_trigger bmst_trigger_checker chk_u (.clk_sys, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
  .wb_ack, .word_valid, .message_start, .trig_in, .trig_out, .capture_event, .capture_active,
  .status_pattern, .trig_irq, .trig_irq_tcb);

// ### dv/bmst_bus_model.sv
`timescale 1ns/1ns

// ****
// bus traffic and trigger pin source
// ****
module bmst_bus_model
(
  // clock
  input wire logic clk_sys,
  // decoded words
  output logic word_valid,
  output logic [15:0] fault_vec,
  output logic [10:0] status_bits,
  output logic message_start,
  // pin
  output logic trig_in
);
  initial
  begin
    word_valid = 1'b0;
    fault_vec = 16'h0000;
    status_bits = 11'h000;
    message_start = 1'b0;
    trig_in = 1'b0;
  end

  // idle fault lines carry the inverse, so ignoring word_valid shows up
  task automatic send_word(input logic [15:0] f);
    @(posedge clk_sys);
    word_valid <= 1'b1;
    fault_vec <= f;
    status_bits <= {11{f[11]}};
    @(posedge clk_sys);
    word_valid <= 1'b0;
    fault_vec <= ~f;
    status_bits <= ~{11{f[11]}};
  endtask : send_word

  task automatic pulse_ext(input int n);
    @(posedge clk_sys);
    trig_in <= 1'b1;
    repeat (n) @(posedge clk_sys);
    trig_in <= 1'b0;
  endtask : pulse_ext

  task automatic pulse_msg;
    @(posedge clk_sys);
    message_start <= 1'b1;
    @(posedge clk_sys);
    message_start <= 1'b0;
  endtask : pulse_msg
endmodule : bmst_bus_model

// ### dv/tb_top.sv
`timescale 1ns/1ns
`include "bmst_regs.svh"

`define CHK(nm, e, g) \
  n_checks++; \
  if ((g) !== (e)) \
  begin \
    $display("FAIL %s exp %h got %h", nm, e, g); \
    error_cnt++; \
  end

module tb_top;
  typedef struct packed {
    logic [1:0] kind;
    logic str;
    logic irq;
    logic [7:0] clr;
    logic [7:0] set;
    logic [15:0] sel;
    logic [15:0] flt;
    logic [7:0] pat0;
    logic fire;
    logic [7:0] pexp;
  } bmst_row_type;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack, word_valid, message_start, trig_in, trig_out, capture_event, capture_active, trig_irq;
  logic [15:0] fault_vec;
  logic [10:0] status_bits;
  logic [7:0] status_pattern, trig_irq_tcb;
  logic [31:0] q;
  int error_cnt = 0;
  int n_checks = 0;
  int cnt = 0;
  bmst_row_type rows [9];

  bmst_bus_model m_u (.clk_sys, .word_valid, .fault_vec, .status_bits, .message_start, .trig_in);

  bmst_trigger dut_u (.clk_sys, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
    .wb_dat_r, .wb_ack, .word_valid, .other_bus_reply_fault(fault_vec[14]),
    .low_word_count_fault(fault_vec[13]), .high_word_count_fault(fault_vec[12]),
    .status_exception_bits(status_bits), .terminal_address_fault(fault_vec[10]),
    .early_response_fault(fault_vec[9]), .illegal_command_fault(fault_vec[8]),
    .dual_channel_transmit_fault(fault_vec[7]), .interword_spacing_fault(fault_vec[6]),
    .inverted_sync_fault(fault_vec[5]), .word_check_bit_fault(fault_vec[4]),
    .low_bit_count_fault(fault_vec[3]), .high_bit_count_fault(fault_vec[2]),
    .biphase_coding_fault(fault_vec[1]), .no_response_fault(fault_vec[0]), .message_start,
    .trig_in, .trig_out, .capture_event, .capture_active, .status_pattern, .trig_irq, .trig_irq_tcb);

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat_w <= d;
    t = 0;
    do
    begin
      @(posedge clk_sys);
      t++;
    end
    while (wb_ack !== 1'b1 && t < 20);
    if (wb_ack !== 1'b1) error_cnt++;
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic cfg(input logic [7:0] idx, input logic [31:0] c, input logic [15:0] s);
    wb(1'b1, `BMST_TIDX_OFS, {24'h000000, idx});
    wb(1'b1, `BMST_TCFG_OFS, c);
    wb(1'b1, `BMST_TFLT_OFS, {16'hffff, s});
  endtask : cfg

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(1'b0, `BMST_EXCM_OFS, 32'h0);
    `CHK("exc mask", 32'h000007ff, q)
    `CHK("pattern", 8'h00, status_pattern)
  endtask : do_reset

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    rows = '{
      '{2'h0, 1'h1, 1'h0, 8'h00, 8'h0f, 16'h0010, 16'h0010, 8'h00, 1'h1, 8'h0f},
      '{2'h0, 1'h0, 1'h1, 8'hf0, 8'h00, 16'h2010, 16'h2000, 8'hff, 1'h1, 8'h0f},
      '{2'h0, 1'h1, 1'h1, 8'hff, 8'h3c, 16'h8000, 16'h0001, 8'h81, 1'h1, 8'h3c},
      '{2'h0, 1'h1, 1'h1, 8'h00, 8'hff, 16'h4000, 16'h2000, 8'h00, 1'h0, 8'h00},
      '{2'h0, 1'h0, 1'h1, 8'h00, 8'h01, 16'h0800, 16'h0800, 8'h00, 1'h1, 8'h01},
      '{2'h1, 1'h1, 1'h1, 8'h00, 8'hff, 16'hffff, 16'hffff, 8'h00, 1'h0, 8'h00},
      '{2'h2, 1'h1, 1'h1, 8'h00, 8'hff, 16'hffff, 16'hffff, 8'h00, 1'h0, 8'h00},
      '{2'h0, 1'h1, 1'h0, 8'h01, 8'h80, 16'h0080, 16'h0080, 8'h01, 1'h1, 8'h80},
      '{2'h0, 1'h0, 1'h0, 8'h00, 8'h02, 16'h5600, 16'h0200, 8'h00, 1'h1, 8'h02}};
    do_reset();
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    wb(1'b1, `BMST_CTRL_OFS, 32'h1);
    m_u.pulse_msg();
    #1;
    `CHK("default start", 1'b1, capture_active)
    foreach (rows[i])
    begin
      cfg(8'(i + 10), {8'h00, rows[i].set, rows[i].clr, 4'h0, rows[i].irq, rows[i].str, rows[i].kind}, rows[i].sel);
      wb(1'b1, `BMST_SLOT_OFS, 32'(i + 10));
      wb(1'b1, `BMST_CTRL_OFS, 32'h4);
      wb(1'b1, `BMST_PATT_OFS, {24'h0, rows[i].pat0});
      m_u.send_word(rows[i].flt);
      #1;
      `CHK("fire", rows[i].fire, capture_event)
      `CHK("strobe", rows[i].fire & rows[i].str, trig_out)
      `CHK("irq", rows[i].fire & rows[i].irq, trig_irq)
      `CHK("pattern", rows[i].pexp, status_pattern)
    end
    wb(1'b1, `BMST_EXCM_OFS, 32'h0);
    cfg(8'h1e, 32'h00000008, 16'h0800);
    wb(1'b1, `BMST_SLOT_OFS, 32'h1e);
    m_u.send_word(16'h0800);
    #1;
    `CHK("masked status", 1'b0, capture_event)
    cfg(8'h1f, 32'h00aaff09, 16'h0000);
    wb(1'b1, `BMST_SLOT_OFS, 32'h1f1e);
    wb(1'b1, `BMST_CTRL_OFS, 32'hc);
    fork
      m_u.pulse_ext(8);
      repeat (14)
      begin
        @(posedge clk_sys);
        #1;
        cnt = cnt + int'(capture_event);
      end
    join
    `CHK("ext fire count", 1, cnt)
    `CHK("irq index", 8'h1f, trig_irq_tcb)
    `CHK("ext pattern", 8'haa, status_pattern)
    wb(1'b0, `BMST_STAT_OFS, 32'h0);
    `CHK("last index", 8'h1f, q[7:0])
    // both slots hit one word with stop mode: slot 1 clears what slot 0 set
    cfg(8'h20, 32'h00f00f08, 16'h0010);
    wb(1'b1, `BMST_SLOT_OFS, 32'h200a);
    wb(1'b1, `BMST_CTRL_OFS, 32'he);
    m_u.send_word(16'h0010);
    #1;
    `CHK("stop capture", 1'b0, capture_active)
    `CHK("both slots pattern", 8'hf0, status_pattern)
    `CHK("both slots strobe", 1'b1, trig_out)
    `CHK("both slots irq index", 8'h20, trig_irq_tcb)
    wb(1'b0, `BMST_STAT_OFS, 32'h0);
    `CHK("both slots last index", 8'h0a, q[7:0])
    wb(1'b1, `BMST_SLOT_OFS, 32'hfefe);
    m_u.send_word(16'hffff);
    #1;
    `CHK("slot beyond store", 1'b0, capture_event)
    @(posedge clk_sys);
    do_reset();
    stop_test();
  end
endmodule : tb_top
